// ===== ll_params.svh
// Timing counts, field positions, offsets and reset values of the low latency port
`ifndef LL_PARAMS_SVH
`define LL_PARAMS_SVH
// System clock and the link clock divided from it
`define LL_CLK_NS 25
`define LL_LINK_NS (2 * `LL_CLK_NS)
// Row cycle time at the fastest rate, rounded up to link cycles
`define LL_TRC_NS 20
`define LL_TRC_MIN ((`LL_TRC_NS + `LL_LINK_NS - 1) / `LL_LINK_NS)
// Refresh window and command count, spacing rounded down to system cycles
`define LL_REF_WIN_NS 32000000
`define LL_REF_CMDS 65536
`define LL_REF_INT_CYC (`LL_REF_WIN_NS / `LL_REF_CMDS / `LL_CLK_NS)
// Command pin codes as {we_n, ref_n}
`define LL_PIN_MODE 2'h0
`define LL_PIN_WRITE 2'h1
`define LL_PIN_REFRESH 2'h2
`define LL_PIN_READ 2'h3
// Mode word fields on the address pins
`define LL_MR_RL_LSB 0
`define LL_MR_BL_LSB 3
`define LL_MR_MUX_BIT 5
`define LL_MR_TRC_LSB 6
// Address split: column, row and the low half sent first in mux mode
`define LL_ROW_LSB 11
`define LL_MUX_LOW_W 11
// Mode reset values
`define LL_RL_RST 3'h3
`define LL_BL_RST 2'h0
// Controller register offsets and fields
`define LL_REG_CTRL 8'h00
`define LL_REG_ADDR 8'h04
`define LL_REG_STAT 8'h08
`define LL_CTRL_BANK_LSB 4
`define LL_CTRL_GO_BIT 8
`define LL_CTRL_REFEN_BIT 12
`define LL_STAT_DONE_BIT 1
`define LL_WD_MASK_BIT 16
`define LL_REFEN_RST 1'h1
`endif

// ===== ll_pkg.sv
// Types shared by both ends of the low latency port
package ll_pkg;
  typedef logic [8:0] ll_word_t;
  typedef logic [20:0] ll_addr_t;
  typedef logic [2:0] ll_bank_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_REFRESH, OP_MODE} ll_op_e;
  typedef enum logic [2:0] {
    C_IDLE = 3'h0, C_CMD2 = 3'h1, C_LAT = 3'h3, C_DATA = 3'h2, C_GAP = 3'h6
  } ll_ctl_fsm_e;
  typedef enum logic [2:0] {R_NONE, R_CTRL, R_ADDR, R_STAT, R_WD, R_RD} ll_reg_e;
  typedef struct packed {
    logic v;
    logic wr;
    ll_bank_t bank;
    ll_addr_t addr;
  } ll_slot_s;
  typedef struct packed {
    logic [2:0] rl;
    logic [1:0] bl;
    logic mux;
    logic [3:0] trc;
    logic mux_pend;
    logic mux_wr;
    ll_bank_t mux_bank;
    logic [10:0] mux_low;
    ll_slot_s [7:0] slot;
    logic [7:0][3:0] busy;
    logic [7:0][12:0] ref_row;
    logic bact;
    logic bwr;
    logic [1:0] bbeat;
    logic [12:0] bbase;
    logic qk;
    ll_word_t q_r;
    ll_word_t q_f;
    logic qv;
    logic trc_err;
    logic [12:0] last_ref;
  } ll_dev_state_s;
  typedef struct packed {
    logic ck;
    ll_ctl_fsm_e fsm;
    logic [3:0] cnt;
    logic [2:0] beat;
    ll_op_e op;
    ll_bank_t bank;
    ll_addr_t addr;
    logic refen;
    logic go;
    logic busy;
    logic done;
    logic [4:0] rtim;
    logic rdue;
    ll_bank_t rbank;
    logic [2:0] rl;
    logic [1:0] bl;
    logic mux;
    logic [3:0] trc;
    ll_word_t [7:0] wd;
    logic [7:0] wm;
    ll_word_t [7:0] rd;
    logic cs_n;
    logic [1:0] cmd;
    ll_addr_t pa;
    ll_bank_t pb;
    ll_word_t w_r;
    ll_word_t w_f;
    logic m_r;
    logic m_f;
    logic rdy;
    logic err;
    logic [31:0] prd;
  } ll_ctl_state_s;
  // Word pairs per burst: burst code 0, 1, 2 gives 2, 4, 8 words
  function automatic logic [2:0] ll_beats(input logic [1:0] bl);
    ll_beats = 3'h1 << bl;
  endfunction
endpackage

// ===== ll_link_if.sv
// Link between the memory controller and the memory device
interface ll_link_if;
  import ll_pkg::*;
  logic command_clock;
  logic write_data_clock;
  logic read_data_clock;
  logic cs_n;
  logic we_n;
  logic ref_n;
  ll_addr_t addr;
  ll_bank_t bank;
  ll_word_t wdata_rise;
  ll_word_t wdata_fall;
  logic write_data_mask_rise;
  logic write_data_mask_fall;
  ll_word_t rdata_rise;
  ll_word_t rdata_fall;
  logic read_data_valid;
  modport dev (
    input command_clock, write_data_clock, cs_n, we_n, ref_n, addr, bank,
    input wdata_rise, wdata_fall, write_data_mask_rise, write_data_mask_fall,
    output read_data_clock, rdata_rise, rdata_fall, read_data_valid
  );
  modport ctl (
    output command_clock, write_data_clock, cs_n, we_n, ref_n, addr, bank,
    output wdata_rise, wdata_fall, write_data_mask_rise, write_data_mask_fall,
    input read_data_clock, rdata_rise, rdata_fall, read_data_valid
  );
endinterface

// ===== ll_dev_end.sv
// Memory device end of the low latency port: command decode, banks, bursts
`include "ll_params.svh"

module ll_dev_end
  import ll_pkg::*;
(
  // Link to the controller
  ll_link_if.dev link,
  // Control in the command clock domain
  input wire logic reset,
  input wire logic ce,
  // Status
  output logic [2:0] cfg_read_latency,
  output logic [1:0] cfg_burst_len,
  output logic trc_violation,
  output logic [12:0] last_refresh_row
);

  //////////////////////////////////////////////////////////////////////////////
  // State and storage

  ll_dev_state_s st;
  ll_dev_state_s nxt;
  ll_word_t mem [0:8191];
  logic [12:0] ix0;
  logic [12:0] ix1;
  logic we0;
  logic we1;
  logic cur_v;
  logic cur_wr;
  logic [1:0] cur_beat;
  logic [12:0] cur_base;
  logic [2:0] nb;
  logic [5:0] colmask;
  logic new_v;
  ll_slot_s new_slot;
  logic touch_v;
  ll_bank_t touch_bank;
  logic [12:0] row_now;

  // Base word of a burst, low column bits cleared for the burst counter
  function automatic logic [12:0] base_of(input ll_bank_t b, input ll_addr_t a,
                                           input logic [5:0] m);
    base_of = {b, a[`LL_ROW_LSB +: 4], a[5:0] & ~m};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt = st;
    new_v = 1'h0;
    new_slot = '0;
    touch_v = 1'h0;
    touch_bank = link.bank;
    row_now = st.ref_row[link.bank];
    nb = ll_beats(st.bl);
    colmask = {2'h0, {nb, 1'h0} - 4'h1};
    // Output data clock toggles every cycle, idle or not
    nxt.qk = ~st.qk;
    // Latency line advances one slot per cycle
    for (int i = 0; i < 7; i++) begin
      nxt.slot[i] = st.slot[i + 1];
    end
    nxt.slot[7] = '0;
    // Per-bank row cycle timers run down independently
    for (int b = 0; b < 8; b++) begin
      if (st.busy[b] != 4'h0) begin
        nxt.busy[b] = st.busy[b] - 4'h1;
      end
    end
    // Command decode, pins sampled at the command clock rise
    if (st.mux_pend) begin
      // Second address cycle carries the upper address half
      nxt.mux_pend = 1'h0;
      new_v = 1'h1;
      new_slot.v = 1'h1;
      new_slot.wr = st.mux_wr;
      new_slot.bank = st.mux_bank;
      new_slot.addr = {link.addr[9:0], st.mux_low};
      touch_v = 1'h1;
      touch_bank = st.mux_bank;
    end else if (!link.cs_n) begin
      unique case ({link.we_n, link.ref_n})
        `LL_PIN_MODE: begin
          nxt.rl = link.addr[`LL_MR_RL_LSB +: 3];
          if (link.addr[`LL_MR_BL_LSB +: 2] != 2'h3) begin
            nxt.bl = link.addr[`LL_MR_BL_LSB +: 2];
          end
          nxt.mux = link.addr[`LL_MR_MUX_BIT];
          nxt.trc = link.addr[`LL_MR_TRC_LSB +: 4];
          if (link.addr[`LL_MR_TRC_LSB +: 4] < 4'(`LL_TRC_MIN)) begin
            nxt.trc = 4'(`LL_TRC_MIN);
          end
        end
        `LL_PIN_REFRESH: begin
          // Row comes from the bank's own counter, not the address pins
          nxt.ref_row[link.bank] = row_now + 13'h1;
          nxt.last_ref = row_now;
          touch_v = 1'h1;
        end
        `LL_PIN_WRITE, `LL_PIN_READ: begin
          if (st.mux) begin
            nxt.mux_pend = 1'h1;
            nxt.mux_wr = !link.we_n;
            nxt.mux_bank = link.bank;
            nxt.mux_low = link.addr[`LL_MUX_LOW_W - 1:0];
          end else begin
            new_v = 1'h1;
            new_slot.v = 1'h1;
            new_slot.wr = !link.we_n;
            new_slot.bank = link.bank;
            new_slot.addr = link.addr;
            touch_v = 1'h1;
          end
        end
      endcase
    end
    // A command to a bank still inside its row cycle is flagged
    if (touch_v) begin
      if (st.busy[touch_bank] != 4'h0) begin
        nxt.trc_err = 1'h1;
      end
      nxt.busy[touch_bank] = st.trc;
    end
    // Reads and writes enter at the same depth, so latencies match
    if (new_v) begin
      nxt.slot[st.rl] = new_slot;
    end
    // Burst beat in this cycle: a slot reaching the end or a running burst
    cur_v = 1'h0;
    cur_wr = 1'h0;
    cur_beat = 2'h0;
    cur_base = st.bbase;
    if (st.slot[0].v) begin
      cur_v = 1'h1;
      cur_wr = st.slot[0].wr;
      cur_base = base_of(st.slot[0].bank, st.slot[0].addr, colmask);
    end else if (st.bact) begin
      cur_v = 1'h1;
      cur_wr = st.bwr;
      cur_beat = st.bbeat;
    end
    // Two words per beat, burst counter fills the low column bits
    ix0 = {cur_base[12:6], cur_base[5:0] | {3'h0, cur_beat, 1'h0}};
    ix1 = ix0 | 13'h1;
    // Write words stored only where the mask lane is low
    we0 = cur_v && cur_wr && !link.write_data_mask_rise;
    we1 = cur_v && cur_wr && !link.write_data_mask_fall;
    // Read words and their valid flag
    nxt.qv = cur_v && !cur_wr;
    nxt.q_r = '0;
    nxt.q_f = '0;
    if (cur_v && !cur_wr) begin
      nxt.q_r = mem[ix0];
      nxt.q_f = mem[ix1];
    end
    // Advance or close the burst
    nxt.bact = 1'h0;
    if (cur_v && ({1'h0, cur_beat} + 3'h1 != nb)) begin
      nxt.bact = 1'h1;
      nxt.bwr = cur_wr;
      nxt.bbeat = cur_beat + 2'h1;
      nxt.bbase = cur_base;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // All control state, frozen while the clock enable is low
  always_ff @(posedge link.command_clock) begin
    if (reset) begin
      st <= '0;
      st.rl <= `LL_RL_RST;
      st.bl <= `LL_BL_RST;
      st.trc <= 4'(`LL_TRC_MIN);
    end else if (ce) begin
      st <= nxt;
    end
  end

  // Storage array, two write ports for the word pair
  always_ff @(posedge link.command_clock) begin
    if (ce && !reset && we0) begin
      mem[ix0] <= link.wdata_rise;
    end
    if (ce && !reset && we1) begin
      mem[ix1] <= link.wdata_fall;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Read lanes and clock straight from their flip-flops
  assign link.read_data_clock = st.qk;
  assign link.rdata_rise = st.q_r;
  assign link.rdata_fall = st.q_f;
  assign link.read_data_valid = st.qv;
  assign cfg_read_latency = st.rl;
  assign cfg_burst_len = st.bl;
  assign trc_violation = st.trc_err;
  assign last_refresh_row = st.last_ref;

endmodule

// ===== ll_ctl_end.sv
// Memory controller end: APB registers, link clock divider, command sequencer
//
// Design decisions made here: the register addresses and register access over APB.
`include "ll_params.svh"

module ll_ctl_end
  import ll_pkg::*;
(
  // System clock and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device
  ll_link_if.ctl link
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  ll_ctl_state_s st;
  ll_ctl_state_s nxt;
  ll_reg_e sel;
  logic acc;
  logic [2:0] nb;
  logic [2:0] wi;

  // Register decode by word address
  function automatic ll_reg_e reg_of(input logic [7:0] a);
    reg_of = R_NONE;
    if (a[1:0] == 2'h0) begin
      if (a == `LL_REG_CTRL) reg_of = R_CTRL;
      else if (a == `LL_REG_ADDR) reg_of = R_ADDR;
      else if (a == `LL_REG_STAT) reg_of = R_STAT;
      else if (a[7:5] == 3'h1) reg_of = R_WD;
      else if (a[7:5] == 3'h2) reg_of = R_RD;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt = st;
    sel = reg_of(paddr);
    acc = psel && penable && st.rdy;
    nb = ll_beats(st.bl);
    wi = {st.beat[1:0], 1'h0};
    // Link clock divider; commands move on its falling half
    nxt.ck = ~st.ck;
    // APB: no wait states, data and error prepared in setup
    nxt.rdy = psel && !penable;
    if (psel && !penable) begin
      nxt.err = (sel == R_NONE) || (pwrite && sel == R_RD);
      unique case (sel)
        R_CTRL: nxt.prd = {19'h0, st.refen, 5'h0, st.bank, 2'h0, st.op};
        R_ADDR: nxt.prd = {11'h0, st.addr};
        R_STAT: nxt.prd = {30'h0, st.done, st.busy};
        R_WD: nxt.prd = {15'h0, st.wm[paddr[4:2]], 7'h0, st.wd[paddr[4:2]]};
        R_RD: nxt.prd = {23'h0, st.rd[paddr[4:2]]};
        R_NONE: nxt.prd = 32'h0;
      endcase
    end
    if (acc && pwrite && !st.err) begin
      unique case (sel)
        R_CTRL: begin
          nxt.op = ll_op_e'(pwdata[1:0]);
          nxt.bank = pwdata[`LL_CTRL_BANK_LSB +: 3];
          nxt.refen = pwdata[`LL_CTRL_REFEN_BIT];
          if (pwdata[`LL_CTRL_GO_BIT] && !st.busy) begin
            nxt.go = 1'h1;
            nxt.busy = 1'h1;
          end
        end
        R_ADDR: nxt.addr = pwdata[20:0];
        R_STAT: if (pwdata[`LL_STAT_DONE_BIT]) nxt.done = 1'h0;
        R_WD: begin
          nxt.wd[paddr[4:2]] = pwdata[8:0];
          nxt.wm[paddr[4:2]] = pwdata[`LL_WD_MASK_BIT];
        end
        default: nxt.err = st.err;
      endcase
    end
    // Command sequencer, one step per link cycle
    if (st.ck) begin
      nxt.cs_n = 1'h1;
      unique case (st.fsm)
        C_IDLE: begin
          if (st.rdue && st.refen) begin
            // Refresh banks in turn to spread rows over the window
            nxt.cs_n = 1'h0;
            nxt.cmd = `LL_PIN_REFRESH;
            nxt.pb = st.rbank;
            nxt.rbank = st.rbank + 3'h1;
            nxt.rdue = 1'h0;
            // Marks an automatic refresh so a pending go is not closed early
            nxt.beat = 3'h7;
            nxt.cnt = st.trc;
            nxt.fsm = C_GAP;
          end else if (st.go) begin
            nxt.cs_n = 1'h0;
            nxt.pb = st.bank;
            nxt.pa = st.addr;
            nxt.cnt = st.trc;
            nxt.fsm = C_GAP;
            nxt.beat = 3'h0;
            unique case (st.op)
              OP_MODE: begin
                nxt.cmd = `LL_PIN_MODE;
                nxt.rl = st.addr[`LL_MR_RL_LSB +: 3];
                if (st.addr[`LL_MR_BL_LSB +: 2] != 2'h3) begin
                  nxt.bl = st.addr[`LL_MR_BL_LSB +: 2];
                end
                nxt.mux = st.addr[`LL_MR_MUX_BIT];
                nxt.trc = st.addr[`LL_MR_TRC_LSB +: 4];
                if (st.addr[`LL_MR_TRC_LSB +: 4] < 4'(`LL_TRC_MIN)) begin
                  nxt.trc = 4'(`LL_TRC_MIN);
                end
              end
              OP_REFRESH: nxt.cmd = `LL_PIN_REFRESH;
              OP_READ, OP_WRITE: begin
                nxt.cmd = (st.op == OP_READ) ? `LL_PIN_READ : `LL_PIN_WRITE;
                nxt.cnt = {1'h0, st.rl} + 4'h1;
                nxt.fsm = st.mux ? C_CMD2 : C_LAT;
                if (st.mux) begin
                  nxt.pa = {10'h0, st.addr[`LL_MUX_LOW_W - 1:0]};
                end
              end
            endcase
          end
        end
        C_CMD2: begin
          nxt.pa = {11'h0, st.addr[20:`LL_MUX_LOW_W]};
          nxt.fsm = C_LAT;
        end
        C_LAT: begin
          nxt.cnt = st.cnt - 4'h1;
          if (st.cnt == 4'h1) begin
            nxt.fsm = C_DATA;
            if (st.op == OP_WRITE) begin
              // First pair goes out read latency plus one link cycles after the command
              nxt.w_r = st.wd[0];
              nxt.w_f = st.wd[1];
              nxt.m_r = st.wm[0];
              nxt.m_f = st.wm[1];
              nxt.beat = 3'h1;
            end
          end
        end
        C_DATA: begin
          if (st.op == OP_WRITE) begin
            if (st.beat < nb) begin
              nxt.w_r = st.wd[wi];
              nxt.w_f = st.wd[wi | 3'h1];
              nxt.m_r = st.wm[wi];
              nxt.m_f = st.wm[wi | 3'h1];
              nxt.beat = st.beat + 3'h1;
            end else begin
              nxt.m_r = 1'h1;
              nxt.m_f = 1'h1;
              nxt.cnt = st.trc;
              nxt.fsm = C_GAP;
            end
          end else if (link.read_data_valid) begin
            nxt.rd[wi] = link.rdata_rise;
            nxt.rd[wi | 3'h1] = link.rdata_fall;
            nxt.beat = st.beat + 3'h1;
            if (st.beat + 3'h1 == nb) begin
              nxt.cnt = st.trc;
              nxt.fsm = C_GAP;
            end
          end
        end
        C_GAP: begin
          // Hold off the next command for a full row cycle
          if (st.cnt == 4'h0) begin
            nxt.fsm = C_IDLE;
            if (st.go && st.beat != 3'h7) begin
              nxt.go = 1'h0;
              nxt.busy = 1'h0;
              nxt.done = 1'h1;
            end
          end else begin
            nxt.cnt = st.cnt - 4'h1;
          end
        end
        default: nxt.fsm = C_IDLE;
      endcase
    end
    // Refresh spacing timer; a due mark set here wins over the clear above
    if (st.rtim == 5'(`LL_REF_INT_CYC - 1)) begin
      nxt.rtim = 5'h0;
      nxt.rdue = 1'h1;
    end else begin
      nxt.rtim = st.rtim + 5'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // All state, frozen while the clock enable is low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= '0;
      st.fsm <= C_IDLE;
      st.cs_n <= 1'h1;
      st.cmd <= `LL_PIN_READ;
      st.m_r <= 1'h1;
      st.m_f <= 1'h1;
      st.rl <= `LL_RL_RST;
      st.bl <= `LL_BL_RST;
      st.trc <= 4'(`LL_TRC_MIN);
      st.refen <= `LL_REFEN_RST;
    end else if (ce) begin
      st <= nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus answer and link pins straight from flip-flops
  assign prdata = st.prd;
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign link.command_clock = st.ck;
  assign link.write_data_clock = st.ck;
  assign link.cs_n = st.cs_n;
  assign link.we_n = st.cmd[1];
  assign link.ref_n = st.cmd[0];
  assign link.addr = st.pa;
  assign link.bank = st.pb;
  assign link.wdata_rise = st.w_r;
  assign link.wdata_fall = st.w_f;
  assign link.write_data_mask_rise = st.m_r;
  assign link.write_data_mask_fall = st.m_f;

endmodule

// ===== ll_link_sva.sv
// Link checker: command, data and clock timing between both ends
module ll_link_sva
  import ll_pkg::*;
(
  // Link clock and device reset
  input wire logic command_clock,
  input wire logic reset,
  // Link pins
  input wire logic read_data_clock,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire ll_addr_t addr,
  input wire logic write_data_mask_rise,
  input wire logic read_data_valid,
  // Device status
  input wire logic [2:0] cfg_read_latency,
  input wire logic [1:0] cfg_burst_len,
  input wire logic trc_violation
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] since_rd;
  logic [4:0] since_wr;
  logic [3:0] vrun;
  logic mux_ff;
  logic rd_cmd;
  logic wr_cmd;
  logic mode_cmd;
  default clocking cb @(posedge command_clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // Command decode on the pins
  assign rd_cmd = !cs_n && we_n && ref_n;
  assign wr_cmd = !cs_n && !we_n && ref_n;
  assign mode_cmd = !cs_n && !we_n && !ref_n;
  // Cycles since last read and write, length of a valid run, mux mode
  always_ff @(posedge command_clock) begin
    if (reset) begin
      since_rd <= 5'h1f;
      since_wr <= 5'h1f;
      vrun <= 4'h0;
      mux_ff <= 1'b0;
    end else begin
      since_rd <= rd_cmd ? 5'h01 : since_rd + {4'h0, since_rd != 5'h1f};
      since_wr <= wr_cmd ? 5'h01 : since_wr + {4'h0, since_wr != 5'h1f};
      vrun <= read_data_valid ? vrun + 4'h1 : 4'h0;
      if (mode_cmd) begin
        mux_ff <= addr[5];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_QK_TOGGLES:
    assert property (!$past(reset) |-> read_data_clock != $past(read_data_clock))
    else $error("read data clock stalled");
  AST_READ_ANSWERS:
    assert property (rd_cmd |-> ##[2:10] read_data_valid)
    else $error("read got no valid data");
  AST_READ_LATENCY:
    assert property ($rose(read_data_valid) |-> since_rd >= cfg_read_latency + 5'h2
      && since_rd <= cfg_read_latency + 5'h2 + {4'h0, mux_ff})
    else $error("read data at wrong latency");
  AST_VALID_RUN:
    assert property ($fell(read_data_valid) |-> vrun == (4'h1 << cfg_burst_len))
    else $error("valid run does not match burst");
  AST_WRITE_LATENCY:
    assert property ($fell(write_data_mask_rise) |-> since_wr >= cfg_read_latency + 5'h1
      && since_wr <= cfg_read_latency + 5'h1 + {4'h0, mux_ff})
    else $error("write data at wrong latency");
  AST_NO_TRC:
    assert property (!trc_violation)
    else $error("bank hit inside row cycle");
  AST_REF_NO_DATA:
    assert property (!cs_n && we_n && !ref_n |-> !read_data_valid [*3])
    else $error("refresh produced read data");
  AST_CFG_FROM_MODE:
    assert property ($changed(cfg_burst_len) || $changed(cfg_read_latency)
      |-> $past(mode_cmd) || $past(mode_cmd, 2) || $past(mode_cmd, 3))
    else $error("settings changed without mode command");
endmodule

// ===== low_latency_ddr_dram_port_tb.sv
// Bench: controller and device joined over the link, driven through APB
module low_latency_ddr_dram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic dev_reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] cfg_rl;
  logic [1:0] cfg_bl;
  logic trc_err;
  logic [12:0] ref_row;
  logic [31:0] rng = 32'h1f;
  logic [31:0] rdv;
  logic perr;
  logic [8:0] w1 [8];
  logic [8:0] w2 [8];
  logic [2:0] rl;
  logic [1:0] bl;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  ll_link_if ll_link_if_i ();
  ll_ctl_end ll_ctl_end_i (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(ll_link_if_i.ctl));
  ll_dev_end ll_dev_end_i (.link(ll_link_if_i.dev), .reset(dev_reset), .ce(1'b1),
    .cfg_read_latency(cfg_rl), .cfg_burst_len(cfg_bl), .trc_violation(trc_err),
    .last_refresh_row(ref_row));
  ll_link_sva ll_link_sva_i (.command_clock(ll_link_if_i.command_clock), .reset(dev_reset),
    .read_data_clock(ll_link_if_i.read_data_clock), .cs_n(ll_link_if_i.cs_n),
    .we_n(ll_link_if_i.we_n), .ref_n(ll_link_if_i.ref_n), .addr(ll_link_if_i.addr),
    .write_data_mask_rise(ll_link_if_i.write_data_mask_rise),
    .read_data_valid(ll_link_if_i.read_data_valid), .cfg_read_latency(cfg_rl),
    .cfg_burst_len(cfg_bl), .trc_violation(trc_err));
  ////////////////////////////////////////////////////////////////
  // System clock and hang limit
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, idle cycle first so strobes never clash
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Answer taken at the rising edge that samples pready high
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start a link command and wait for done, refresh kept off
  task automatic run_op(input logic [1:0] k, input logic [2:0] b, input logic [20:0] a);
    int n;
    n = 0;
    apb(1'b1, 8'h04, {11'h0, a});
    apb(1'b1, 8'h00, {23'h0, 1'b1, 1'b0, b, 2'h0, k});
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rdv[1] !== 1'b1 && n < 100);
    check({31'h0, rdv[1]}, 32'h1);
    apb(1'b1, 8'h08, 32'h2);
  endtask
  task automatic finish_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Mode, masked write and read back per burst length, then refresh
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge ll_link_if_i.command_clock);
    dev_reset <= 1'b0;
    check({29'h0, cfg_rl}, 32'h3);
    check({30'h0, cfg_bl}, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b0, 8'hfc, 32'h0);
    check({31'h0, perr}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      rl = rng[2:0];
      bl = 2'(i % 3);
      run_op(2'h3, 3'h0, {11'h0, rng[5:3], 1'b1, i > 2, bl, rl});
      check({29'h0, cfg_rl}, {29'h0, rl});
      check({30'h0, cfg_bl}, {30'h0, bl});
      for (int j = 0; j < (2 << bl); j++) begin
        rng = xs(rng);
        w1[j] = rng[8:0];
        w2[j] = rng[17:9];
        apb(1'b1, 8'h20 + 8'(4 * j), {23'h0, w1[j]});
      end
      run_op(2'h1, rng[20:18], rng[31:11]);
      for (int j = 0; j < (2 << bl); j++) begin
        apb(1'b1, 8'h20 + 8'(4 * j), {15'h0, j[0], 7'h0, w2[j]});
      end
      run_op(2'h1, rng[20:18], rng[31:11]);
      run_op(2'h0, rng[20:18], rng[31:11]);
      for (int j = 0; j < (2 << bl); j++) begin
        apb(1'b0, 8'h40 + 8'(4 * j), 32'h0);
        check(rdv, {23'h0, j[0] ? w1[j] : w2[j]});
      end
    end
    // Burst code 3 is ignored, latency still taken
    run_op(2'h3, 3'h0, {11'h0, 4'h1, 1'b0, 2'h3, 3'h2});
    check({30'h0, cfg_bl}, {30'h0, bl});
    check({29'h0, cfg_rl}, 32'h2);
    run_op(2'h2, 3'h5, 21'h1abcd);
    check({19'h0, ref_row}, 32'h0);
    run_op(2'h2, 3'h5, 21'h0);
    check({19'h0, ref_row}, 32'h1);
    check({31'h0, trc_err}, 32'h0);
    finish_test();
  end
endmodule
